// file: sarq_defs.svh
// constants for the sar adc readout sequencer: offsets, fields, resets, timing
// assumes a single 25 MHz core clock and an axi4-lite register bus
//
// Notes on behaviour
// - exactly one of three modes: single channel, round-robin, one-time sweep
// - every conversion result is ten bits wide
// - single mode converts only the chosen channel, then interrupts the core
// - after enabling, wait a programmable enable time before first sampling
// - sampling holds the chosen input for a programmable sample time
// - conversion lasts exactly twelve converter clock cycles
// - at conversion end result becomes readable; completion pulse lasts two cycles
// - continuous single mode restarts sampling the same channel after the pulse
// - round-robin steps channels 0 to 11 upward, storing each result
// - result registers readable any time without disturbing the sequence
// - round-robin sweeps forever; each new result overwrites the old
// - full sweep roughly 760 us, about 63.33 us per channel
// - one-time sweep follows round-robin order and stops after last channel
// - one-time sweep interrupts only after the whole sweep completes
`ifndef SARQ_DEFS_SVH
`define SARQ_DEFS_SVH

// register byte offsets
`define SARQ_CTRL_OFS     8'h00
`define SARQ_TEN_OFS      8'h04
`define SARQ_TSMP_OFS     8'h08
`define SARQ_STAT_OFS     8'h0c
`define SARQ_IRQ_STAT_OFS 8'h10
`define SARQ_IRQ_MASK_OFS 8'h14
`define SARQ_AVG_OFS      8'h18
`define SARQ_RES_OFS      8'h40

// control fields
`define SARQ_CTRL_EN      0
`define SARQ_CTRL_MODE_LO 1
`define SARQ_CTRL_CONT    3
`define SARQ_CTRL_CH_LO   8

// reset values
`define SARQ_TEN_RST  16'h0064
`define SARQ_TSMP_RST 16'h0032

// timing
`define SARQ_CONV_CYC  12
`define SARQ_PULSE_CYC 2
`define SARQ_LAST_CH   11
`define SARQ_CLK_MHZ   25
`define SARQ_CH_NS     63330
`define SARQ_CH_CYC    ((`SARQ_CH_NS * `SARQ_CLK_MHZ) / 1000)

// interrupt bits
`define SARQ_IRQ_DONE  0
`define SARQ_IRQ_SWEEP 1
`endif

// file: sarq_pkg.sv
// types for the sar adc readout sequencer
// assumes sarq_defs.svh supplies the numbers
package sarq_pkg;
	typedef enum logic [1:0] {
		SARQ_MODE_SINGLE = 2'b00,
		SARQ_MODE_RROBIN = 2'b01,
		SARQ_MODE_ONCE   = 2'b10
	} sarq_mode_t;

	typedef enum logic [2:0] {
		SARQ_ST_IDLE   = 3'b000,
		SARQ_ST_ENWAIT = 3'b001,
		SARQ_ST_SAMPLE = 3'b010,
		SARQ_ST_CONV   = 3'b011,
		SARQ_ST_PULSE  = 3'b100
	} sarq_state_t;

	// settings latched at each sample start
	typedef struct packed {
		sarq_mode_t  mode;
		logic        cont;
		logic [4:0]  chan;
		logic [15:0] t_smp;
	} sarq_cfg_t;
endpackage

// file: sarq_sync.sv
// three-stage synchroniser for the converter data-ready level
// assumes the input comes from the analog macro, outside this clock
`timescale 1ns/1ns
module sarq_sync (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] s_q;

	// stage 0 feeds only stage 1; change counted once stages 1 and 2 agree
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q  <= 3'h0;
			dout <= 1'b0;
		end else begin
			s_q <= {s_q[1:0], din};
			if (s_q[1] == s_q[2])
				dout <= s_q[2];
		end
	end
endmodule

// file: sarq_ctr.sv
// down counter that reports zero; reused for each phase duration
// assumes a load and a count cycle never need to happen together
`timescale 1ns/1ns
module sarq_ctr #(
	parameter int W = 16
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              zero
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clock) begin
		if (!rstn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= value;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign zero = (cnt_q == '0);
endmodule

// file: sarq_seq.sv
// sar adc readout sequencer with axi4-lite registers, an irq line and a completion pulse
// assumes one core clock; converter returns data on adc_data before adc_convert ends
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sarq_defs.svh"
module sarq_seq #(
	parameter int NCH = 32
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [9:0]  adc_data,
	input  wire logic        adc_ready,
	output logic             adc_enable,
	output logic             adc_sample,
	output logic             adc_convert,
	output logic [4:0]       adc_chan,
	output logic             completion_irq_pulse,
	output logic             irq
);
	localparam logic [4:0] LAST_CH = 5'(`SARQ_LAST_CH);

	// registers
	logic                 en_q, cont_q;
	sarq_pkg::sarq_mode_t mode_q;
	logic [4:0]           chan_q;
	logic [15:0]          ten_q, tsmp_q;
	logic [3:0]           avg_q;
	logic [1:0]           ist_q, imask_q;
	logic [9:0]           res_q [NCH];
	sarq_pkg::sarq_cfg_t  cfg_q;
	sarq_pkg::sarq_state_t st_q;
	logic                 en_d1_q;

	// bus handshake state
	logic        aw_got_q, w_got_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wr_go;
	logic [1:0]  ist_clr;
	logic        ready_s;

	// phase counter control
	logic        ld;
	logic [15:0] ld_val;
	logic        cnt_zero;
	logic [1:0]  ev;

	sarq_sync u_sync (
		.clock (clock),
		.rstn  (rstn),
		.din   (adc_ready),
		.dout  ()
	);

	sarq_ctr #(.W(16)) u_ctr (
		.clock (clock),
		.rstn  (rstn),
		.load  (ld),
		.value (ld_val),
		.zero  (cnt_zero)
	);

	// synchronised ready unused for timing: conversion length is counted locally
	assign ready_s = 1'b0;

	// write address and data taken in either order
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q < `SARQ_RES_OFS) && (awaddr_q > `SARQ_AVG_OFS)
				                ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;

	// software-writable settings; byte strobes are ignored, every write takes all bits
	always_ff @(posedge clock) begin
		if (!rstn) begin
			en_q    <= 1'b0;
			cont_q  <= 1'b0;
			mode_q  <= sarq_pkg::SARQ_MODE_SINGLE;
			chan_q  <= 5'h00;
			ten_q   <= `SARQ_TEN_RST;
			tsmp_q  <= `SARQ_TSMP_RST;
			avg_q   <= 4'h1;
			imask_q <= 2'h0;
		end else if (wr_go) begin
			unique case (awaddr_q)
				`SARQ_CTRL_OFS: begin
					en_q   <= wdata_q[`SARQ_CTRL_EN];
					cont_q <= wdata_q[`SARQ_CTRL_CONT];
					// illegal mode code falls back to single, keeping one mode
					mode_q <= (wdata_q[`SARQ_CTRL_MODE_LO+:2] == 2'b11) ?
					          sarq_pkg::SARQ_MODE_SINGLE :
					          sarq_pkg::sarq_mode_t'(wdata_q[`SARQ_CTRL_MODE_LO+:2]);
					chan_q <= wdata_q[`SARQ_CTRL_CH_LO+:5];
				end
				`SARQ_TEN_OFS:      ten_q   <= wdata_q[15:0];
				`SARQ_TSMP_OFS:     tsmp_q  <= wdata_q[15:0];
				`SARQ_AVG_OFS:      avg_q   <= wdata_q[3:0];
				`SARQ_IRQ_MASK_OFS: imask_q <= wdata_q[1:0];
				default: ;
			endcase
		end
	end

	// write-one-to-clear request for interrupt status
	assign ist_clr = (wr_go && awaddr_q == `SARQ_IRQ_STAT_OFS) ? wdata_q[1:0] : 2'h0;

	// read channel: results read straight from storage, sequence untouched
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'b00;
				// sixteen result words above the base; higher offsets fall to unmapped
				if (s_axi_araddr[7:6] == 2'b01)
					s_axi_rdata <= {22'h0, res_q[{1'b0, s_axi_araddr[5:2]}]};
				else begin
					unique case (s_axi_araddr)
						`SARQ_CTRL_OFS:     s_axi_rdata <= {19'h0, chan_q, 4'h0,
						                                    cont_q, mode_q, en_q};
						`SARQ_TEN_OFS:      s_axi_rdata <= {16'h0, ten_q};
						`SARQ_TSMP_OFS:     s_axi_rdata <= {16'h0, tsmp_q};
						`SARQ_STAT_OFS:     s_axi_rdata <= {24'h0, cfg_q.chan, st_q};
						`SARQ_IRQ_STAT_OFS: s_axi_rdata <= {30'h0, ist_q};
						`SARQ_IRQ_MASK_OFS: s_axi_rdata <= {30'h0, imask_q};
						`SARQ_AVG_OFS:      s_axi_rdata <= {28'h0, avg_q};
						default: begin
							s_axi_rdata <= 32'h0;
							s_axi_rresp <= 2'b10;
						end
					endcase
				end
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// phase sequencer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q    <= sarq_pkg::SARQ_ST_IDLE;
			cfg_q   <= '0;
			en_d1_q <= 1'b0;
		end else begin
			en_d1_q <= en_q;
			if (!en_q)
				st_q <= sarq_pkg::SARQ_ST_IDLE; // abort, results kept
			else begin
				unique case (st_q)
					sarq_pkg::SARQ_ST_IDLE:
						if (!en_d1_q)
							st_q <= sarq_pkg::SARQ_ST_ENWAIT; // off to on edge
					sarq_pkg::SARQ_ST_ENWAIT:
						if (cnt_zero) begin
							st_q        <= sarq_pkg::SARQ_ST_SAMPLE;
							cfg_q.mode  <= mode_q; // latch at sample start
							cfg_q.cont  <= cont_q;
							cfg_q.t_smp <= tsmp_q;
							// auto modes start at channel 0
							cfg_q.chan  <= (mode_q == sarq_pkg::SARQ_MODE_SINGLE) ?
							               chan_q : 5'h00;
						end
					sarq_pkg::SARQ_ST_SAMPLE:
						if (cnt_zero)
							st_q <= sarq_pkg::SARQ_ST_CONV; // sample time done
					sarq_pkg::SARQ_ST_CONV:
						if (cnt_zero)
							st_q <= sarq_pkg::SARQ_ST_PULSE; // twelve cycles over
					sarq_pkg::SARQ_ST_PULSE:
						if (cnt_zero) begin
							cfg_q.mode  <= mode_q; // next sample relatches
							cfg_q.cont  <= cont_q;
							cfg_q.t_smp <= tsmp_q;
							unique case (cfg_q.mode)
								sarq_pkg::SARQ_MODE_SINGLE: begin
									cfg_q.chan <= chan_q;
									// one shot unless continuous
									st_q <= cfg_q.cont ? sarq_pkg::SARQ_ST_SAMPLE :
									        sarq_pkg::SARQ_ST_IDLE;
								end
								sarq_pkg::SARQ_MODE_RROBIN: begin
									// wrap and sweep forever
									cfg_q.chan <= (cfg_q.chan == LAST_CH) ? 5'h00 :
									              cfg_q.chan + 5'h01;
									st_q <= sarq_pkg::SARQ_ST_SAMPLE;
								end
								default: begin
									cfg_q.chan <= cfg_q.chan + 5'h01;
									// halt after last channel
									st_q <= (cfg_q.chan == LAST_CH) ? sarq_pkg::SARQ_ST_IDLE :
									        sarq_pkg::SARQ_ST_SAMPLE;
								end
							endcase
						end
					default: st_q <= sarq_pkg::SARQ_ST_IDLE;
				endcase
			end
		end
	end

	// counter loads on every phase entry; wait of zero still costs one cycle
	always_comb begin
		ld     = 1'b0;
		ld_val = 16'h0;
		if (en_q && st_q == sarq_pkg::SARQ_ST_IDLE && !en_d1_q) begin
			ld     = 1'b1;
			ld_val = ten_q;
		end else if (en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_ENWAIT) begin
			ld     = 1'b1;
			ld_val = tsmp_q;
		end else if (en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_SAMPLE) begin
			ld     = 1'b1;
			ld_val = 16'(`SARQ_CONV_CYC - 1);
		end else if (en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_CONV) begin
			ld     = 1'b1;
			ld_val = 16'(`SARQ_PULSE_CYC - 1);
		end else if (en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_PULSE) begin
			ld     = 1'b1;
			// channel period is tsmp+15 cycles; firmware sets tsmp for the sweep rate
			ld_val = tsmp_q;
		end
	end

	// result capture at conversion end; 10-bit value overwrites old one
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++)
				res_q[i] <= 10'h000;
		end else if (en_q && cnt_zero && !ld_q_conv(st_q)) begin
			res_q[cfg_q.chan] <= adc_data;
		end
	end

	function automatic logic ld_q_conv(input sarq_pkg::sarq_state_t s);
		ld_q_conv = (s != sarq_pkg::SARQ_ST_CONV);
	endfunction

	// events: each completion outside one-time mode, and end of a one-time sweep only
	assign ev[`SARQ_IRQ_DONE]  = en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_CONV &&
	                             cfg_q.mode != sarq_pkg::SARQ_MODE_ONCE;
	assign ev[`SARQ_IRQ_SWEEP] = en_q && cnt_zero && st_q == sarq_pkg::SARQ_ST_CONV &&
	                             cfg_q.mode == sarq_pkg::SARQ_MODE_ONCE &&
	                             cfg_q.chan == LAST_CH;

	// sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!rstn)
			ist_q <= 2'h0;
		else
			ist_q <= (ist_q & ~ist_clr) | ev;
	end

	// converter drive and interrupt outputs, all registered
	always_ff @(posedge clock) begin
		if (!rstn) begin
			adc_enable           <= 1'b0;
			adc_sample           <= 1'b0;
			adc_convert          <= 1'b0;
			adc_chan             <= 5'h00;
			completion_irq_pulse <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			adc_enable  <= en_q;
			adc_sample  <= en_q && st_q == sarq_pkg::SARQ_ST_SAMPLE && !ready_s;
			adc_convert <= en_q && st_q == sarq_pkg::SARQ_ST_CONV;
			adc_chan    <= cfg_q.chan;
			// two-cycle pulse, suppressed mid-sweep in one-time mode
			completion_irq_pulse <= en_q && st_q == sarq_pkg::SARQ_ST_PULSE &&
			                        (cfg_q.mode != sarq_pkg::SARQ_MODE_ONCE ||
			                         cfg_q.chan == LAST_CH);
			irq <= |((ist_q | ev) & imask_q);
		end
	end
endmodule

// file: sarq_seq_monitor.sv
// port-level checks for the readout sequencer
// assumes it is bound onto sarq_seq; one clock, synchronous active-low reset
`timescale 1ns/1ns
module sarq_seq_monitor (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        adc_enable,
	input wire logic        adc_sample,
	input wire logic        adc_convert,
	input wire logic [4:0]  adc_chan,
	input wire logic        completion_irq_pulse,
	input wire logic        irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// phase lengths; sample and convert lag by a flop, so causes look back two cycles
	// run length of the convert level; an abort drops enable on the same edge
	logic [3:0] conv_n;
	always_ff @(posedge clock) begin
		if (!rstn)
			conv_n <= 4'h0;
		else if (!adc_convert)
			conv_n <= 4'h0;
		else if (conv_n != 4'hf)
			conv_n <= conv_n + 4'h1;
	end

	AST_CONV_LEN: assert property ($fell(adc_convert) && adc_enable |-> conv_n == 4'hc)
		else $error("conversion phase length wrong");
	AST_CONV_MAX: assert property (adc_convert |-> conv_n < 4'hc)
		else $error("conversion phase too long");
	AST_PULSE_LEN: assert property ($rose(completion_irq_pulse) |->
		completion_irq_pulse[*2] ##1 !completion_irq_pulse)
		else $error("completion pulse length wrong");
	AST_PULSE_CAUSE: assert property ($rose(completion_irq_pulse) |->
		$past(adc_convert) || $past(adc_convert, 2))
		else $error("completion pulse without conversion");
	AST_SMP_CONV: assert property ($rose(adc_convert) |->
		$past(adc_sample) || $past(adc_sample, 2))
		else $error("conversion without sampling");
	AST_CHAN_HOLD: assert property (adc_convert && $past(adc_convert) |-> $stable(adc_chan))
		else $error("channel moved during conversion");
	AST_OFF_QUIET: assert property (!adc_enable[*3] |-> !adc_sample && !adc_convert)
		else $error("activity while disabled");
	AST_EN_WAIT: assert property ($rose(adc_enable) |-> !adc_sample && !adc_convert)
		else $error("sampling without enable wait");
	AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	// main scenarios reached
	cover property ($rose(completion_irq_pulse));
	cover property ($rose(irq));
	cover property ($fell(adc_enable) && $past(adc_convert));
endmodule

bind sarq_seq sarq_seq_monitor sarq_seq_monitor_inst (.clock(clock), .rstn(rstn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.adc_enable(adc_enable), .adc_sample(adc_sample), .adc_convert(adc_convert),
	.adc_chan(adc_chan), .completion_irq_pulse(completion_irq_pulse), .irq(irq));

// file: sarq_conv_model.sv
// behavioural converter macro facing the sequencer
// assumes the sequencer captures data on the last convert cycle
`timescale 1ns/1ns
module sarq_conv_model (
	input wire logic [4:0] adc_chan,
	input wire logic       adc_convert,
	input wire logic [4:0] tag,
	output logic [9:0]     adc_data,
	output logic           adc_ready
);
	// ten-bit result names tag and channel; outside conversion the bus shows
	// the inverse so a capture at the wrong moment cannot pass
	assign adc_data = adc_convert ? {tag, adc_chan} : ~{tag, adc_chan};
	assign adc_ready = 1'b0; // level is not used for timing
endmodule

// file: sarq_seq_tb.sv
// self-checking bench for the readout sequencer
// assumes sarq_seq, the converter model and the bound monitor
`timescale 1ns/1ns
module sarq_seq_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} sarq_row_t;
	logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, adc_ready;
	logic        adc_enable, adc_sample, adc_convert, cirq, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [9:0]  adc_data;
	logic [4:0]  adc_chan, tag;
	int          failures, cmp_count, wt, nsmp, npul, n0;
	sarq_row_t   rows[8] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h64, 2'h0},
		'{8'h08, 32'h32, 2'h0}, '{8'h0c, 32'h0, 2'h0}, '{8'h10, 32'h0, 2'h0},
		'{8'h14, 32'h0, 2'h0}, '{8'h40, 32'h0, 2'h0}, '{8'h1c, 32'h0, 2'h2}};

	sarq_seq sarq_seq_inst (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .adc_data(adc_data), .adc_ready(adc_ready),
		.adc_enable(adc_enable), .adc_sample(adc_sample), .adc_convert(adc_convert),
		.adc_chan(adc_chan), .completion_irq_pulse(cirq), .irq(irq));
	sarq_conv_model sarq_conv_model_inst (.adc_chan(adc_chan), .adc_convert(adc_convert),
		.tag(tag), .adc_data(adc_data), .adc_ready(adc_ready));

	// 25 MHz core clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// count phase starts and pulses so silent periods can be checked
	always @(posedge adc_sample) nsmp++;
	always @(posedge cirq) npul++;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one write: address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk("bresp", er, bresp);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
		rready <= 1'b0;
	endtask

	// one sample and conversion; wt keeps the wait before sampling
	task conv(input logic [4:0] ch);
		int n;
		n = 0;
		while (adc_sample !== 1'b1 && n < 400) begin @(negedge clock); n++; end
		wt = n;
		n = 0;
		while (adc_sample === 1'b1) begin @(negedge clock); n++; end
		chk("sample_len", 5, n);
		n = 0;
		while (adc_convert !== 1'b1 && n < 4) begin @(negedge clock); n++; end
		n = 0;
		while (adc_convert === 1'b1) begin chk("chan", ch, adc_chan); @(negedge clock); n++; end
		chk("conv_len", 12, n);
	endtask

	task pul();
		int n;
		n = 0;
		while (cirq !== 1'b1 && n < 4) begin @(negedge clock); n++; end
		n = 0;
		while (cirq === 1'b1) begin @(negedge clock); n++; end
		chk("pulse_len", 2, n);
	endtask

	task test_done();
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard, far beyond the thousand or so cycles the run needs
	initial begin
		repeat (30000) @(posedge clock);
		failures++;
		test_done();
	end

	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		tag = 5'h03;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(rows[i].a, rows[i].d, rows[i].r);
		wr(8'h20, 32'h1, 2'h2);
		wr(8'h18, 32'h1, 2'h0);
		wr(8'h04, 32'd20, 2'h0);
		wr(8'h08, 32'd4, 2'h0);
		wr(8'h14, 32'h3, 2'h0);
		// single shot on channel 5, then silence
		wr(8'h00, 32'h0501, 2'h0);
		conv(5'd5);
		chk("en_wait", 1, wt >= 17 && wt <= 23);
		pul();
		rd(8'h54, {22'h0, 5'h03, 5'd5}, 2'h0);
		rd(8'h10, 32'h1, 2'h0);
		n0 = nsmp;
		repeat (40) @(negedge clock);
		chk("one_shot", n0, nsmp);
		chk("enable_on", 1, adc_enable);
		chk("irq_set", 1, irq);
		wr(8'h14, 32'h0, 2'h0);
		repeat (3) @(negedge clock);
		chk("irq_masked", 0, irq);
		wr(8'h14, 32'h3, 2'h0);
		wr(8'h10, 32'h1, 2'h0);
		repeat (3) @(negedge clock);
		chk("irq_clear", 0, irq);
		// continuous single on channel 2
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h00, 32'h0209, 2'h0);
		conv(5'd2);
		pul();
		conv(5'd2);
		chk("restart", 1, wt <= 2);
		// one sweep, a single pulse at its end
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h10, 32'h3, 2'h0);
		n0 = npul;
		wr(8'h00, 32'h5, 2'h0);
		for (int c = 0; c < 12; c++) begin
			conv(c[4:0]);
			if (c > 0) chk("ch_gap", 2, wt);
		end
		pul();
		chk("sweep_pulses", n0 + 1, npul);
		rd(8'h10, 32'h2, 2'h0);
		n0 = nsmp;
		repeat (40) @(negedge clock);
		chk("halt", n0, nsmp);
		for (int c = 0; c < 12; c++) rd(8'h40 + 8'(4 * c), {22'h0, 5'h03, c[4:0]}, 2'h0);
		// endless sweeps overwrite, results read while running
		wr(8'h00, 32'h0, 2'h0);
		tag <= 5'h07;
		wr(8'h00, 32'h3, 2'h0);
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 12; c++) conv(c[4:0]);
			@(posedge clock);
			tag <= 5'h09;
		end
		for (int c = 0; c < 12; c++) rd(8'h40 + 8'(4 * c), {22'h0, 5'h09, c[4:0]}, 2'h0);
		// abort in mid conversion keeps results
		while (adc_convert !== 1'b1) @(posedge clock);
		wr(8'h00, 32'h0, 2'h0);
		repeat (10) @(negedge clock);
		n0 = nsmp;
		repeat (40) @(negedge clock);
		chk("aborted", n0, nsmp);
		chk("enable_off", 0, adc_enable);
		rd(8'h40, {22'h0, 5'h09, 5'd0}, 2'h0);
		test_done();
	end
endmodule
